// ==== pkg/scratchpad_pkg.sv ====
// Shared constants and types for the scratch-pad, bank and stack logic.
`default_nettype none
package scratchpad_pkg;

    // Number of scratch-pad bytes held on chip.
    localparam int unsigned RAM_BYTES = 256;

    // Reset value of the stack top pointer.
    localparam logic [7:0] SP_RESET = 8'h07;

    // Direct address at which the stack top pointer is seen.
    localparam logic [7:0] SP_ADDR = 8'h81;

    // First byte of the bit-addressable scratch-pad range.
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;

    // Position of the two bank select bits in the status word.
    localparam int unsigned PSW_BANK_LO = 3;
    localparam int unsigned PSW_BANK_HI = 4;

    // One bit per address 80h..FFh, set where a register exists.
    // Index is the low seven address bits; top byte is row F8h.
    localparam logic [127:0] SFR_PRESENT =
        128'hfdf9f1ff_b7b7ffcf_f3fffbff_ffcf7fcf;

    // Registers whose writes are guarded by the timed-access window.
    localparam int unsigned TIMED_COUNT = 3;
    localparam logic [7:0] TIMED_ADDR [TIMED_COUNT] = '{
        8'hd8, 8'hab, 8'hae
    };

    // Kind of access that the execution unit asks for.
    typedef enum logic [2:0] {
        ACC_DIRECT = 3'b000,
        ACC_INDIRECT = 3'b001,
        ACC_WORK_REG = 3'b010,
        ACC_BIT = 3'b011,
        ACC_PUSH = 3'b100,
        ACC_POP = 3'b101
    } access_kind_t;

endpackage
`default_nettype wire

// ==== pkg/sfr_decode_if.sv ====
// Carrier between the access logic and the register map decoder.
`timescale 1ns/10ps
`default_nettype none
interface sfr_decode_if;
    logic [7:0] addr;  // Direct address under decode.
    logic present;     // A register exists at this address.
    logic bit_ok;      // The register also takes single-bit access.
    logic timed;       // Writes need the timed-access window.

    // Side that asks about an address.
    modport requester(output addr, input present, input bit_ok,
                      input timed);

    // Side that answers.
    modport decoder(input addr, output present, output bit_ok,
                    output timed);
endinterface
`default_nettype wire

// ==== hw/sfr_map_decoder.sv ====
// Decoder of the special function register map.
`timescale 1ns/10ps
`default_nettype none
module sfr_map_decoder (
    sfr_decode_if.decoder dec
);
    // One match flag per guarded register.
    logic [scratchpad_pkg::TIMED_COUNT-1:0] timed_hit;

    // Compare the address against each guarded register.
    for (genvar g = 0; g < scratchpad_pkg::TIMED_COUNT; g++) begin : g_timed
        assign timed_hit[g] = (dec.addr == scratchpad_pkg::TIMED_ADDR[g]);
    end

    // Only upper-half addresses with an entry in the map are present.
    always_comb begin
        dec.present = dec.addr[7] &
                      scratchpad_pkg::SFR_PRESENT[dec.addr[6:0]];
        // Bit access exists where the low nibble is 0 or 8.
        dec.bit_ok = dec.present & (dec.addr[2:0] == 3'h0);
        // Guarded registers must also exist to count.
        dec.timed = dec.present & (|timed_hit);
    end
endmodule
`default_nettype wire

// ==== hw/scratchpad_bank_stack_addressing.sv ====
// Scratch-pad RAM, working register banks, bit decode and stack pointer.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Four banks of eight byte-wide registers.
// - Status word bank bits select the bank.
// - Registers zero and one supply indirect addresses.
// - Bytes 20h to 2Fh also bit addressable.
// - Access kind alone chooses bit or byte.
// - Registers ending 0 or 8 take bit access.
// - Calls and interrupts push return address; this block only pushes single bytes on request.
// - Stack pointer resets to 07h.
// - Push increments pointer, then writes byte.
// - Pop reads byte, then decrements pointer.
// - Software may write any pointer value.
// - Registers 80-FFh reached by direct addressing only.
// - Unassigned register addresses have no storage.
// - Guarded registers need timed-access window to write.
// - 256 RAM bytes; lower 128 direct and indirect reachable, upper 128 indirect only.
module scratchpad_bank_stack_addressing (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic req_valid_i,
    input wire scratchpad_pkg::access_kind_t req_kind_i,
    input wire logic req_write_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [2:0] req_reg_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic req_bit_i,
    input wire logic [7:0] processor_status_word_i,
    input wire logic timed_access_open_i,
    input wire logic [7:0] sfr_rdata_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic rd_bit_o,
    output logic access_fault_o,
    output logic sfr_req_o,
    output logic sfr_we_o,
    output logic sfr_bit_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic [7:0] stack_top_pointer_o,
    output logic [1:0] active_bank_o
);

    // Scratch-pad storage; the banks are its lowest 32 bytes.
    logic [7:0] ram_q [scratchpad_pkg::RAM_BYTES];

    // Stack top pointer and its next value.
    logic [7:0] sp_q;
    logic [7:0] sp_d;

    // Registered answer and forwarded register access.
    logic rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_bit_q, rd_bit_d;
    logic fault_q, fault_d;
    logic sfr_req_q, sfr_req_d;
    logic sfr_we_q, sfr_we_d;
    logic sfr_bit_q, sfr_bit_d;
    logic [7:0] sfr_addr_q, sfr_addr_d;
    logic [7:0] sfr_wdata_q, sfr_wdata_d;

    // Single RAM write port computed each cycle.
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;

    // Decode of the request.
    logic [1:0] bank;        // Active bank number.
    logic [7:0] ptr_addr;    // Location of the pointer register.
    logic [7:0] reg_addr;    // Location of the named working register.
    logic [7:0] bit_byte;    // Byte that holds an addressed bit.
    logic [2:0] bit_idx;     // Bit position within that byte.
    logic [7:0] tgt;         // Final byte address of the access.
    logic to_sfr;            // Access goes to the register space.
    logic is_sp;             // Access hits the stack top pointer.
    logic is_write;          // Request stores a byte.
    logic refused;           // Guarded write outside the window.
    logic fault;             // Unassigned register, refused write or bit access to a byte-only register.
    logic [7:0] cur_byte;    // Present value of the target byte.
    logic [7:0] new_byte;    // Value to store on a write.

    // Map decoder link.
    sfr_decode_if dec_if ();

    // Register map lookup for the target address.
    sfr_map_decoder u_map (
        .dec(dec_if.decoder)
    );

    assign dec_if.addr = tgt;

    // Address formation for every kind of access.
    always_comb begin
        // Bank bits come from the status word held by the core.
        bank = processor_status_word_i[scratchpad_pkg::PSW_BANK_HI:
                                       scratchpad_pkg::PSW_BANK_LO];
        // Bank bits become address bits 4:3 of a register access.
        reg_addr = {3'b000, bank, req_reg_i};
        // Register zero or one of the bank holds the indirect address.
        ptr_addr = {3'b000, bank, 2'b00, req_reg_i[0]};
        // Lower bit addresses fall in 20h..2Fh, upper ones in the map.
        if (req_addr_i[7]) begin
            bit_byte = {req_addr_i[7:3], 3'b000};
        end else begin
            bit_byte = scratchpad_pkg::BIT_RAM_BASE |
                       {4'h0, req_addr_i[6:3]};
        end
        bit_idx = req_addr_i[2:0];
        // The access kind, not the address, picks the decode path.
        case (req_kind_i)
            scratchpad_pkg::ACC_DIRECT: begin
                tgt = req_addr_i;
                to_sfr = req_addr_i[7];
            end
            scratchpad_pkg::ACC_INDIRECT: begin
                // Indirect addresses always land in RAM, even above 7Fh.
                tgt = ram_q[ptr_addr];
                to_sfr = 1'b0;
            end
            scratchpad_pkg::ACC_WORK_REG: begin
                tgt = reg_addr;
                to_sfr = 1'b0;
            end
            scratchpad_pkg::ACC_BIT: begin
                tgt = bit_byte;
                to_sfr = req_addr_i[7];
            end
            scratchpad_pkg::ACC_PUSH: begin
                // Write lands one above the current top, wrapping.
                tgt = sp_q + 8'h01;
                to_sfr = 1'b0;
            end
            scratchpad_pkg::ACC_POP: begin
                // Read comes from the current top.
                tgt = sp_q;
                to_sfr = 1'b0;
            end
            default: begin
                tgt = 8'h00;
                to_sfr = 1'b0;
            end
        endcase
    end

    // Access qualification, data merge and next state.
    always_comb begin
        is_sp = to_sfr & (tgt == scratchpad_pkg::SP_ADDR);
        is_write = req_valid_i &
                   (req_kind_i != scratchpad_pkg::ACC_POP) &
                   (req_write_i |
                    (req_kind_i == scratchpad_pkg::ACC_PUSH));
        // Writes to guarded registers are refused outside the timed window.
        refused = to_sfr & dec_if.timed & is_write &
                  ~timed_access_open_i;
        // Holes in the register map hold nothing, and a bit access to a
        // byte-only register is refused rather than widened to a byte.
        fault = req_valid_i & to_sfr &
                (~dec_if.present | refused |
                 ((req_kind_i == scratchpad_pkg::ACC_BIT) &
                  ~dec_if.bit_ok));
        // Current value: pointer, peripheral register or RAM.
        if (is_sp) begin
            cur_byte = sp_q;
        end else if (to_sfr) begin
            cur_byte = sfr_rdata_i;
        end else begin
            cur_byte = ram_q[tgt];
        end
        // Bit writes modify one bit and keep the rest.
        new_byte = req_wdata_i;
        if (req_kind_i == scratchpad_pkg::ACC_BIT) begin
            new_byte = cur_byte;
            new_byte[bit_idx] = req_bit_i;
        end

        // RAM write port.
        ram_we = is_write & ~to_sfr;
        ram_waddr = tgt;
        ram_wdata = new_byte;

        // Pointer moves on push and pop, or takes a software write.
        sp_d = sp_q;
        if (req_valid_i & (req_kind_i == scratchpad_pkg::ACC_PUSH)) begin
            sp_d = sp_q + 8'h01;
        end else if (req_valid_i &
                     (req_kind_i == scratchpad_pkg::ACC_POP)) begin
            sp_d = sp_q - 8'h01;
        end else if (is_write & is_sp) begin
            sp_d = new_byte;
        end

        // Answer for every read, including a pop.
        rd_valid_d = req_valid_i & ~is_write;
        rd_data_d = fault ? 8'h00 : cur_byte;
        rd_bit_d = fault ? 1'b0 : cur_byte[bit_idx];
        fault_d = fault;

        // Forward accesses to the peripheral registers outside.
        sfr_req_d = req_valid_i & to_sfr & ~fault & ~is_sp;
        sfr_we_d = is_write & sfr_req_d;
        sfr_bit_d = (req_kind_i == scratchpad_pkg::ACC_BIT) & sfr_req_d;
        sfr_addr_d = sfr_req_d ? tgt : 8'h00;
        sfr_wdata_d = sfr_we_d ? new_byte : 8'h00;
    end

    // Control and answer registers.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp_q <= scratchpad_pkg::SP_RESET;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            rd_bit_q <= 1'b0;
            fault_q <= 1'b0;
            sfr_req_q <= 1'b0;
            sfr_we_q <= 1'b0;
            sfr_bit_q <= 1'b0;
            sfr_addr_q <= 8'h00;
            sfr_wdata_q <= 8'h00;
        end else begin
            sp_q <= sp_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            rd_bit_q <= rd_bit_d;
            fault_q <= fault_d;
            sfr_req_q <= sfr_req_d;
            sfr_we_q <= sfr_we_d;
            sfr_bit_q <= sfr_bit_d;
            sfr_addr_q <= sfr_addr_d;
            sfr_wdata_q <= sfr_wdata_d;
        end
    end

    // Scratch-pad array; contents are not cleared by reset.
    always_ff @(posedge core_clk_i) begin
        if (ram_we) begin
            ram_q[ram_waddr] <= ram_wdata;
        end
    end

    // Outputs straight from flip-flops, except active_bank_o, taken from the status word.
    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;
    assign rd_bit_o = rd_bit_q;
    assign access_fault_o = fault_q;
    assign sfr_req_o = sfr_req_q;
    assign sfr_we_o = sfr_we_q;
    assign sfr_bit_o = sfr_bit_q;
    assign sfr_addr_o = sfr_addr_q;
    assign sfr_wdata_o = sfr_wdata_q;
    assign stack_top_pointer_o = sp_q;
    assign active_bank_o = bank;

    // Push moves the pointer up by one, wrapping at 256.
    a_push_sp_step: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_PUSH)
        |=> sp_q == $past(sp_q) + 8'h01)
        else $error("Push did not raise the stack pointer by one.");

    // Pushed byte sits at the new top.
    a_push_data_top: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_PUSH)
        |=> ram_q[sp_q] == $past(req_wdata_i))
        else $error("Pushed byte not found at the stack top.");

    // Pop returns the old top and then lowers the pointer.
    a_pop_read_first: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_POP)
        |=> rd_valid_o && rd_data_o == $past(ram_q[sp_q]) &&
            sp_q == $past(sp_q) - 8'h01)
        else $error("Pop order or value wrong.");

    // Full pointer wraps to zero on push.
    a_sp_wrap_zero: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_PUSH &&
         sp_q == 8'hff) |=> sp_q == 8'h00)
        else $error("Stack pointer did not wrap.");

    // Software write to the pointer address loads it.
    a_sp_soft_write: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_write_i &&
         req_kind_i == scratchpad_pkg::ACC_DIRECT &&
         req_addr_i == scratchpad_pkg::SP_ADDR)
        |=> sp_q == $past(req_wdata_i) && !sfr_req_o)
        else $error("Stack pointer write lost.");

    // Register access lands in the active bank.
    a_bank_reg_write: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_write_i &&
         req_kind_i == scratchpad_pkg::ACC_WORK_REG)
        |=> ram_q[{3'b000, $past(bank), $past(req_reg_i)}] ==
            $past(req_wdata_i))
        else $error("Working register write in wrong bank.");

    // Indirect access never reaches the register space.
    a_indirect_ram_only: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_INDIRECT)
        |=> !sfr_req_o && !access_fault_o)
        else $error("Indirect access reached the register space.");

    // Unassigned register addresses fault and are not forwarded.
    a_unmapped_fault: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_kind_i == scratchpad_pkg::ACC_DIRECT &&
         req_addr_i[7] && !dec_if.present)
        |=> access_fault_o && !sfr_req_o && rd_data_o == 8'h00 ##1
            !access_fault_o || $past(req_valid_i))
        else $error("Unassigned register address was not refused.");

    // Guarded writes outside the window are dropped.
    a_timed_guard: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_valid_i && req_write_i && dec_if.timed &&
         req_kind_i == scratchpad_pkg::ACC_DIRECT &&
         !timed_access_open_i) |=> !sfr_we_o && access_fault_o)
        else $error("Guarded write passed without the window.");

    // Forwarded bit accesses hit only bit-capable registers.
    a_sfr_bit_align: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        sfr_bit_o |-> sfr_req_o && sfr_addr_o[2:0] == 3'h0)
        else $error("Bit access forwarded to a byte-only register.");

endmodule
`default_nettype wire

// ==== verification/sfr_partner_model.sv ====
// Stand-in for the peripheral registers behind the forwarded accesses.
`timescale 1ns/10ps
`default_nettype none
module sfr_partner_model (
    input wire logic core_clk_i,
    input wire logic [7:0] target_i,
    input wire logic sfr_req_i,
    input wire logic sfr_we_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o
);
    // Register contents, seeded so that every address reads differently.
    logic [7:0] regs_q [256];

    // Seed the contents once at time zero.
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs_q[i] = 8'(i) ^ 8'ha5;
        end
    end

    // The read value follows the register that the request targets.
    assign sfr_rdata_o = regs_q[target_i];

    // A forwarded write lands at the edge after the design raises it.
    always @(posedge core_clk_i) begin
        if (sfr_req_i && sfr_we_i) begin
            regs_q[sfr_addr_i] <= sfr_wdata_i;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_scratchpad_bank_stack_addressing.sv ====
// Self-checking bench for the scratch-pad, bank and stack logic.
`timescale 1ns/10ps
`default_nettype none
module tb_scratchpad_bank_stack_addressing;
    logic clk = 1'b0; // Core clock at 25 MHz.
    logic rst_n = 1'b0; // Reset, active low.
    logic valid = 1'b0; // Request strobe.
    scratchpad_pkg::access_kind_t kind = scratchpad_pkg::ACC_DIRECT;
    logic we = 1'b0; // Write request.
    logic [7:0] addr = 8'h00; // Direct or bit address.
    logic [2:0] rg = 3'h0; // Working register index.
    logic [7:0] wd = 8'h00; // Write byte.
    logic bv = 1'b0; // Bit value.
    logic [7:0] processor_status_word = 8'h00; // Status word.
    logic timed = 1'b0; // Timed-access window open.
    logic [7:0] srd; // Peripheral read value.
    logic [7:0] tgt; // Byte targeted by the request.
    logic rd_valid, rd_bit, fault, sreq, swe, sbit;
    logic [7:0] rd_data, saddr, swd, sp;
    logic [1:0] bank;
    int fail_count = 0; // Mismatches seen.
    int total_checks = 0; // Comparisons made.

    // The clock toggles every half period.
    always #20 clk = ~clk;

    // Bit addresses above 7Fh land on the byte with the low bits cleared.
    assign tgt = (kind == scratchpad_pkg::ACC_BIT) ? {addr[7:3], 3'h0} : addr;

    scratchpad_bank_stack_addressing i_dut (
        .core_clk_i(clk), .reset_n_i(rst_n), .req_valid_i(valid),
        .req_kind_i(kind), .req_write_i(we), .req_addr_i(addr),
        .req_reg_i(rg), .req_wdata_i(wd), .req_bit_i(bv),
        .processor_status_word_i(processor_status_word), .timed_access_open_i(timed),
        .sfr_rdata_i(srd), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .rd_bit_o(rd_bit), .access_fault_o(fault), .sfr_req_o(sreq),
        .sfr_we_o(swe), .sfr_bit_o(sbit), .sfr_addr_o(saddr),
        .sfr_wdata_o(swd), .stack_top_pointer_o(sp), .active_bank_o(bank)
    );

    sfr_partner_model i_sfr (
        .core_clk_i(clk), .target_i(tgt), .sfr_req_i(sreq),
        .sfr_we_i(swe), .sfr_addr_i(saddr), .sfr_wdata_i(swd),
        .sfr_rdata_o(srd)
    );

    // One request, driven at a falling edge; the answer is settled at the
    // next falling edge and stands until the following rising edge.
    task automatic op(input scratchpad_pkg::access_kind_t k, input logic w,
        input logic [7:0] a, input logic [2:0] r, input logic [7:0] d,
        input logic b);
        valid = 1'b1;
        kind = k;
        we = w;
        addr = a;
        rg = r;
        wd = d;
        bv = b;
        @(negedge clk);
    endtask

    // Direct byte access.
    task automatic dir(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        op(scratchpad_pkg::ACC_DIRECT, w, a, 3'h0, d, 1'b0);
    endtask

    // Working register access in the active bank.
    task automatic wreg(input logic w, input logic [2:0] r,
        input logic [7:0] d);
        op(scratchpad_pkg::ACC_WORK_REG, w, 8'h00, r, d, 1'b0);
    endtask

    // Single-bit access.
    task automatic bitop(input logic w, input logic [7:0] a, input logic b);
        op(scratchpad_pkg::ACC_BIT, w, a, 3'h0, 8'h00, b);
    endtask

    // Stack push of one byte.
    task automatic push(input logic [7:0] d);
        op(scratchpad_pkg::ACC_PUSH, 1'b1, 8'h00, 3'h0, d, 1'b0);
    endtask

    // Stack pop of one byte.
    task automatic pop;
        op(scratchpad_pkg::ACC_POP, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0);
    endtask

    // Indirect access through pointer register zero or one.
    task automatic ind(input logic w, input logic r, input logic [7:0] d);
        op(scratchpad_pkg::ACC_INDIRECT, w, 8'h00, {2'b00, r}, d, 1'b0);
    endtask

    // Drops the strobe for one cycle so forwarded writes can land.
    task automatic idle;
        valid = 1'b0;
        @(negedge clk);
    endtask

    // Byte comparison.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Flag comparison.
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(40 * 3000);
        fail_count++;
        final_report();
    end

    // Main sequence of tests.
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk8(sp, scratchpad_pkg::SP_RESET);
        $display("test reset done");
        // Push two bytes, read them in place, then pop them back.
        push(8'hab);
        chk8(sp, 8'h08);
        chk1(rd_valid, 1'b0);
        push(8'hcd);
        chk8(sp, 8'h09);
        dir(1'b0, 8'h08, 8'h00);
        chk8(rd_data, 8'hab);
        dir(1'b0, 8'h09, 8'h00);
        chk8(rd_data, 8'hcd);
        pop();
        chk1(rd_valid, 1'b1);
        chk8(rd_data, 8'hcd);
        chk8(sp, 8'h08);
        pop();
        chk8(rd_data, 8'hab);
        chk8(sp, 8'h07);
        // Move the pointer to the top and wrap across zero.
        dir(1'b1, scratchpad_pkg::SP_ADDR, 8'hff);
        chk8(sp, 8'hff);
        chk1(sreq, 1'b0);
        push(8'h5a);
        chk8(sp, 8'h00);
        dir(1'b0, 8'h00, 8'h00);
        chk8(rd_data, 8'h5a);
        pop();
        chk8(sp, 8'hff);
        dir(1'b0, scratchpad_pkg::SP_ADDR, 8'h00);
        chk8(rd_data, 8'hff);
        dir(1'b1, scratchpad_pkg::SP_ADDR, 8'h07);
        $display("test stack done");
        // Each bank's first and last register seen at 8n and 8n+7.
        for (int b = 0; b < 4; b++) begin
            processor_status_word = 8'(b * 8);
            for (int r = 0; r < 8; r += 7) begin
                wreg(1'b1, 3'(r), 8'(b * 16 + r));
                chk8({6'h00, bank}, 8'(b));
                dir(1'b0, 8'(b * 8 + r), 8'h00);
                chk8(rd_data, 8'(b * 16 + r));
                wreg(1'b0, 3'(r), 8'h00);
                chk8(rd_data, 8'(b * 16 + r));
            end
        end
        processor_status_word = 8'h00;
        wreg(1'b0, 3'h7, 8'h00);
        chk8(rd_data, 8'h07);
        $display("test banks done");
        // Indirect access through the pointer registers of bank 2.
        processor_status_word = 8'h10;
        wreg(1'b1, 3'h1, 8'h40);
        dir(1'b1, 8'h40, 8'h77);
        ind(1'b0, 1'b1, 8'h00);
        chk8(rd_data, 8'h77);
        wreg(1'b1, 3'h0, 8'h90);
        ind(1'b1, 1'b0, 8'h3c);
        chk1(sreq, 1'b0);
        ind(1'b0, 1'b0, 8'h00);
        chk8(rd_data, 8'h3c);
        dir(1'b0, 8'h90, 8'h00);
        chk1(sreq, 1'b1);
        chk8(rd_data, 8'h35);
        processor_status_word = 8'h00;
        $display("test indirect done");
        // Bit access into the bit-addressable bytes.
        dir(1'b1, 8'h0a, 8'h5a);
        dir(1'b1, 8'h21, 8'h00);
        bitop(1'b1, 8'h0a, 1'b1);
        dir(1'b0, 8'h21, 8'h00);
        chk8(rd_data, 8'h04);
        dir(1'b0, 8'h0a, 8'h00);
        chk8(rd_data, 8'h5a);
        bitop(1'b0, 8'h0a, 1'b0);
        chk1(rd_bit, 1'b1);
        bitop(1'b1, 8'h7f, 1'b1);
        dir(1'b0, 8'h2f, 8'h00);
        chk1(rd_data[7], 1'b1);
        $display("test bits done");
        // Forwarded register writes, bit merge and an unassigned address.
        dir(1'b1, 8'h90, 8'h3c);
        chk1(swe, 1'b1);
        chk8(saddr, 8'h90);
        chk8(swd, 8'h3c);
        idle();
        bitop(1'b1, 8'h90, 1'b1);
        chk1(sbit, 1'b1);
        chk8(swd, 8'h3d);
        idle();
        bitop(1'b0, 8'h91, 1'b0);
        chk1(rd_bit, 1'b0);
        dir(1'b0, 8'h84, 8'h00);
        chk1(fault, 1'b1);
        chk1(rd_valid, 1'b1);
        chk8(rd_data, 8'h00);
        chk1(sreq, 1'b0);
        $display("test registers done");
        // Guarded writes refused with the window shut, taken when open.
        for (int i = 0; i < scratchpad_pkg::TIMED_COUNT; i++) begin
            timed = 1'b0;
            dir(1'b1, scratchpad_pkg::TIMED_ADDR[i], 8'h55);
            chk1(fault, 1'b1);
            chk1(sreq, 1'b0);
            timed = 1'b1;
            dir(1'b1, scratchpad_pkg::TIMED_ADDR[i], 8'h55);
            chk1(sreq, 1'b1);
            chk1(fault, 1'b0);
        end
        timed = 1'b0;
        idle();
        $display("test timed done");
        // A reset in mid-run puts a moved pointer back to its start value.
        dir(1'b1, scratchpad_pkg::SP_ADDR, 8'h3f);
        chk8(sp, 8'h3f);
        rst_n = 1'b0;
        idle();
        chk8(sp, scratchpad_pkg::SP_RESET);
        chk1(rd_valid, 1'b0);
        rst_n = 1'b1;
        idle();
        chk8(sp, scratchpad_pkg::SP_RESET);
        $display("test mid reset done");
        final_report();
    end
endmodule
`default_nettype wire
